// *** clock_sysref_config_regs_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module clock_sysref_config_regs_test
	import csr_pkg::*;
;
	localparam int SW = 12;
	// Cycle ceiling, well above the few hundred cycles the run needs
	localparam int LIMIT = 6000;
	// Stimulus, every input has a value at time zero
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [CSR_ADDR_W-1:0] reg_addr = '0;
	logic [CSR_DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sysref_pin = 1'b0;
	logic sample_marker_output_enable = 1'b0;
	logic [CSR_DECIM_W-1:0] decim_factor = CSR_DECIM_BYPASS;
	logic [SW-1:0] sample_in = '0;
	logic [CSR_POS_W-1:0] sysref_edge_position_in = '0;
	// Observed outputs
	logic [CSR_DATA_W-1:0] reg_rdata;
	logic [SW-1:0] sample_out;
	logic sysref_aligned;
	logic [CSR_SEL_MSB:0] sysref_delay_select;
	logic device_clock_dc_coupled_mode;
	logic sysref_dc_coupled_mode;
	logic sysref_polarity_invert;
	logic sysref_marker_in_lsb_enable;
	logic level_converter_gain_high;
	logic analog_supply_noise_suppress;
	logic [1:0] sample_clock_delay_select;
	logic [CSR_RANGE_W-1:0] input_a_range_trim;
	logic input_a_range_low;
	// Reference model of the register contents
	logic [7:0] c1_m;
	logic [7:0] c2_m;
	logic [7:0] sel_m;
	logic [15:0] rng_m;
	// Pin history, newest first
	logic hist[$];
	// Awkward control 2 codes: reserved bit, both non-one-hot delays
	logic [7:0] tbl2 [5] = '{8'h16, 8'h0a, 8'he3, 8'h24, 8'h01};
	// Range landmarks and the code just below the minimum
	logic [15:0] tblr [5] = '{16'h2000, 16'hffff, 16'h1fff, 16'h0000, 16'ha000};
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;

	csr_clock_sysref_regs #(.SAMPLE_W(SW)) i_csr_clock_sysref_regs (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sysref_pin(sysref_pin),
		.sample_marker_output_enable(sample_marker_output_enable),
		.decim_factor(decim_factor), .sample_in(sample_in), .sample_out(sample_out),
		.sysref_aligned(sysref_aligned), .sysref_edge_position_in(sysref_edge_position_in),
		.sysref_delay_select(sysref_delay_select),
		.device_clock_dc_coupled_mode(device_clock_dc_coupled_mode),
		.sysref_dc_coupled_mode(sysref_dc_coupled_mode),
		.sysref_polarity_invert(sysref_polarity_invert),
		.sysref_marker_in_lsb_enable(sysref_marker_in_lsb_enable),
		.level_converter_gain_high(level_converter_gain_high),
		.analog_supply_noise_suppress(analog_supply_noise_suppress),
		.sample_clock_delay_select(sample_clock_delay_select),
		.input_a_range_trim(input_a_range_trim), .input_a_range_low(input_a_range_low)
	);

	// 50 MHz clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// Verdict and end of run
	task automatic results;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			$display("[ERR] %0t cycle limit reached", $time);
			results();
		end
	end

	// Case-equality compare, so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One-cycle write; effect visible after the sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; data stand only in the following cycle
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
	endtask

	// Write then read back with no gap between the strobes
	task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
		input string what);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
	endtask

	// All static control outputs except the range-low flag against the model
	task automatic check_outs;
		chk({28'h0, sysref_marker_in_lsb_enable, device_clock_dc_coupled_mode,
			sysref_dc_coupled_mode, sysref_polarity_invert}, {28'h0, c1_m[3:0]}, "ctrl1 outs");
		chk({28'h0, level_converter_gain_high, analog_supply_noise_suppress,
			sample_clock_delay_select}, {28'h0, c2_m[4], c2_m[2], c2_m[1:0]}, "ctrl2 outs");
		chk({12'h0, input_a_range_trim, sysref_delay_select}, {12'h0, rng_m, sel_m[3:0]},
			"range sel outs");
	endtask

	// Reset held for 16 cycles, model back to its reset values
	task automatic reset_seq;
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		c1_m = CSR_CTRL1_RST;
		c2_m = 8'h11;
		sel_m = 8'h00;
		rng_m = 16'ha000;
		#1;
	endtask

	// Random pin and samples; aligned lags pin by three edges, output by one
	task automatic run_path(input int n);
		logic [SW-1:0] prev;
		logic [SW-1:0] exp;
		logic p;
		hist.delete();
		for (int j = 0; j < n; j++) begin
			@(posedge ref_clk);
			prev = sample_in;
			p = 1'($urandom());
			sysref_pin <= p;
			hist.push_front(p);
			sample_in <= SW'($urandom());
			#1;
			if (hist.size() > 4) begin
				chk({31'h0, sysref_aligned}, {31'h0, hist[3] ^ c1_m[0]}, "aligned");
				exp = prev;
				// Marker only with both enables and no decimation
				if (c1_m[3] && sample_marker_output_enable && decim_factor == 6'h01) begin
					exp[0] = hist[4] ^ c1_m[0];
				end
				chk({20'h0, sample_out}, {20'h0, exp}, "sample out");
			end
		end
	endtask

	// Main sequence
	initial begin
		logic [7:0] v;
		logic [15:0] r;
		logic [23:0] p;
		logic [3:0] s;
		void'($urandom(58815));
		reset_seq();
		check_outs();
		rchk(CSR_OFS_CTRL1, 32'h0, "ctrl1 reset");
		rchk(CSR_OFS_CTRL2, 32'h11, "ctrl2 reset");
		rchk(CSR_OFS_RANGE_A, 32'ha000, "range reset");
		rchk(CSR_OFS_SEL_CTRL, 32'h0, "sel reset");
		@(posedge ref_clk);
		#1;
		chk(reg_rdata, 32'h0, "rdata idle");
		// Every mix of marker, invert, output enable and decimation
		for (int c = 0; c < 16; c++) begin
			v = 8'($urandom());
			v[3] = c[0];
			v[0] = c[1];
			@(posedge ref_clk);
			sample_marker_output_enable <= c[2];
			decim_factor <= c[3] ? 6'h01 : 6'($urandom_range(63, 2));
			c1_m = v;
			wrrd(CSR_OFS_CTRL1, {24'($urandom()), v}, {24'h0, v}, "ctrl1 back");
			check_outs();
			run_path(14);
		end
		// Non-one-hot delay codes leave the delay untouched
		for (int k = 0; k < 10; k++) begin
			v = (k < 5) ? tbl2[k] : 8'($urandom());
			wr(CSR_OFS_CTRL2, {24'h0, v});
			c2_m = (v[1:0] == 2'b01 || v[1:0] == 2'b10) ? v : {v[7:2], c2_m[1:0]};
			check_outs();
			rchk(CSR_OFS_CTRL2, {24'h0, c2_m}, "ctrl2 back");
		end
		// Range codes at the landmarks, below the minimum, and random
		for (int k = 0; k < 8; k++) begin
			r = (k < 5) ? tblr[k] : 16'($urandom());
			wr(CSR_OFS_RANGE_A, {16'($urandom()), r});
			rng_m = r;
			check_outs();
			@(posedge ref_clk);
			#1;
			chk({31'h0, input_a_range_low}, {31'h0, r < 16'h2000}, "range low");
			rchk(CSR_OFS_RANGE_A, {16'h0, r}, "range back");
		end
		// Delay selection, upper bits stored but inert
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom());
			wr(CSR_OFS_SEL_CTRL, {24'h0, v});
			sel_m = v;
			check_outs();
			rchk(CSR_OFS_SEL_CTRL, {24'h0, v}, "sel back");
		end
		// Position word is read only and follows the detector
		for (int k = 0; k < 4; k++) begin
			p = 24'($urandom());
			@(posedge ref_clk);
			sysref_edge_position_in <= p;
			wr(CSR_OFS_POS, $urandom());
			rchk(CSR_OFS_POS, {8'h0, p}, "position");
			// Software steers the delay to the lowest position bit that is clear
			s = 4'h0;
			for (int b = 15; b >= 0; b--) begin
				if (!p[b]) begin
					s = 4'(b);
				end
			end
			wr(CSR_OFS_SEL_CTRL, {28'h0, s});
			sel_m = {4'h0, s};
			check_outs();
		end
		// Unmapped places read zero and absorb writes
		rchk(8'h31, 32'h0, "unmapped read");
		wr(8'h31, 32'hffff_ffff);
		wr(8'h2f, 32'hffff_ffff);
		check_outs();
		rchk(CSR_OFS_RANGE_A, {16'h0, rng_m}, "range kept");
		// Second reset in mid-run
		reset_seq();
		check_outs();
		rchk(CSR_OFS_CTRL2, 32'h11, "ctrl2 re-reset");
		results();
	end
endmodule
`default_nettype wire

// *** csr_clock_sysref_regs.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Function
// (R1) Marker in sample LSB when both enables set
// (R2) Marker only with decimation factor one
// (R3) Polarity bit inverts SYSREF before alignment
// (R4) Bit 2 selects DC-coupled device clock receiver
// (R5) Bit 1 selects DC-coupled SYSREF receiver
// (R6) Level converter gain bit, resets high
// (R7) Software enables analog supply noise suppression
// (R8) Sample clock delay one-hot, resets 0x1
// (R9) Read 24-bit SYSREF edge position status
// (R10) Software picks delay from position word
// (R11) Input A range code, resets 0xa000
// (R12) Software avoids range codes below 0x2000
// (R13) Control 2 resets 0x11, control 1 0x00
// (R14) Delay select picks detector capture delay
// (R15) Reserved control bits stored, read back, inert
module csr_clock_sysref_regs
	import csr_pkg::*;
#(
	parameter int SAMPLE_W = 12
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [CSR_ADDR_W-1:0] reg_addr,
	input wire logic [CSR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CSR_DATA_W-1:0] reg_rdata,
	input wire logic sysref_pin,
	input wire logic sample_marker_output_enable,
	input wire logic [CSR_DECIM_W-1:0] decim_factor,
	input wire logic [SAMPLE_W-1:0] sample_in,
	output logic [SAMPLE_W-1:0] sample_out,
	output logic sysref_aligned,
	input wire logic [CSR_POS_W-1:0] sysref_edge_position_in,
	output logic [CSR_SEL_MSB:0] sysref_delay_select,
	output logic device_clock_dc_coupled_mode,
	output logic sysref_dc_coupled_mode,
	output logic sysref_polarity_invert,
	output logic sysref_marker_in_lsb_enable,
	output logic level_converter_gain_high,
	output logic analog_supply_noise_suppress,
	output logic [1:0] sample_clock_delay_select,
	output logic [CSR_RANGE_W-1:0] input_a_range_trim,
	output logic input_a_range_low
);

	// Address match helper, shared by write and read decode
	function automatic logic reg_hit(
		input logic [CSR_ADDR_W-1:0] addr,
		input logic [CSR_ADDR_W-1:0] ofs
	);
		reg_hit = (addr == ofs);
	endfunction

	// Two-bit value has exactly one bit set
	function automatic logic is_one_hot2(input logic [1:0] v);
		is_one_hot2 = (v == 2'h1) || (v == 2'h2);
	endfunction

	// Stored control registers
	logic [7:0] sel_ctrl_q; // Holds SYSREF delay selection
	logic [7:0] ctrl1_q; // Clock control 1
	logic [7:0] ctrl2_q; // Clock control 2
	logic [CSR_RANGE_W-1:0] range_a_q; // Input A full-scale code
	logic [CSR_POS_W-1:0] pos_q; // Captured edge position word
	logic range_low_q; // Range code under recommended floor
	logic [CSR_DATA_W-1:0] rdata_q; // Read answer register

	// Decoded write strobes
	logic wr_sel;
	logic wr_c1;
	logic wr_c2;
	logic wr_range;

	// Next value of the delay field
	logic [1:0] delay_d;

	// Write decode, one strobe per writable register; the position word has none
	assign wr_sel = reg_wr && reg_hit(reg_addr, CSR_OFS_SEL_CTRL);
	assign wr_c1 = reg_wr && reg_hit(reg_addr, CSR_OFS_CTRL1);
	assign wr_c2 = reg_wr && reg_hit(reg_addr, CSR_OFS_CTRL2);
	assign wr_range = reg_wr && reg_hit(reg_addr, CSR_OFS_RANGE_A);

	// Delay select register, whole byte stored
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sel_ctrl_q <= CSR_SEL_CTRL_RST;
		end else if (wr_sel) begin
			// Upper bits kept for readback only
			sel_ctrl_q <= reg_wdata[7:0]; // (R14)
		end
	end

	// Clock control 1, reserved upper nibble stored as written
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl1_q <= CSR_CTRL1_RST; // (R13)
		end else if (wr_c1) begin
			ctrl1_q <= reg_wdata[7:0]; // (R15)
		end
	end

	// Delay field accepts only one-hot codes
	always_comb begin
		// Default keeps the present setting
		delay_d = ctrl2_q[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB];
		if (is_one_hot2(reg_wdata[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB])) begin
			// Legal code goes through
			delay_d = reg_wdata[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB]; // (R8)
		end
	end

	// Clock control 2; a bad delay code would leave two or no taps
	// selected, so the field quietly keeps its old value instead
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl2_q <= CSR_CTRL2_RST; // (R13) (R6) (R8)
		end else if (wr_c2) begin
			ctrl2_q <= {reg_wdata[7:2], delay_d}; // (R15)
		end
	end

	// Input A full-scale code; any value accepted
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			range_a_q <= CSR_RANGE_A_RST; // (R11)
		end else if (wr_range) begin
			range_a_q <= reg_wdata[CSR_RANGE_W-1:0]; // (R11)
		end
	end

	// Flag for codes below the recommended floor; low codes still
	// reach the trim, this only lets software see the hazard
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			range_low_q <= 1'b0;
		end else begin
			range_low_q <= (range_a_q < CSR_RANGE_MIN_REC);
		end
	end

	// Edge position word from the window detector, same clock,
	// so it is captured once per cycle with no synchroniser
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pos_q <= CSR_POS_RST;
		end else begin
			pos_q <= sysref_edge_position_in; // (R9)
		end
	end

	// Read answer stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (!reg_rd) begin
			// No read: bus idles at zero
			rdata_q <= '0;
		end else if (reg_hit(reg_addr, CSR_OFS_SEL_CTRL)) begin
			rdata_q <= {24'h000000, sel_ctrl_q};
		end else if (reg_hit(reg_addr, CSR_OFS_CTRL1)) begin
			rdata_q <= {24'h000000, ctrl1_q}; // (R15)
		end else if (reg_hit(reg_addr, CSR_OFS_CTRL2)) begin
			rdata_q <= {24'h000000, ctrl2_q}; // (R15)
		end else if (reg_hit(reg_addr, CSR_OFS_POS)) begin
			rdata_q <= {8'h00, pos_q}; // (R9)
		end else if (reg_hit(reg_addr, CSR_OFS_RANGE_A)) begin
			rdata_q <= {16'h0000, range_a_q};
		end else begin
			// Unmapped offsets answer zero
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

	// Static control levels, straight from register bits
	assign sysref_delay_select = sel_ctrl_q[CSR_SEL_MSB:CSR_SEL_LSB]; // (R14)
	assign device_clock_dc_coupled_mode = ctrl1_q[CSR_C1_DEVCLK_DC_BIT]; // (R4)
	assign sysref_dc_coupled_mode = ctrl1_q[CSR_C1_SREF_DC_BIT]; // (R5)
	assign sysref_polarity_invert = ctrl1_q[CSR_C1_INVERT_BIT]; // (R3)
	assign sysref_marker_in_lsb_enable = ctrl1_q[CSR_C1_MARKER_BIT]; // (R1)
	assign level_converter_gain_high = ctrl2_q[CSR_C2_GAIN_BIT]; // (R6)
	// Software is expected to set this; it costs a little power
	assign analog_supply_noise_suppress = ctrl2_q[CSR_C2_NOISE_BIT];
	assign sample_clock_delay_select = ctrl2_q[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB]; // (R8)
	assign input_a_range_trim = range_a_q; // (R11)
	assign input_a_range_low = range_low_q;

	// SYSREF pin crossing and polarity
	csr_sysref_cond i_csr_sysref_cond (
		.ref_clk(ref_clk),
		.reset(reset),
		.sysref_pin(sysref_pin),
		.invert(ctrl1_q[CSR_C1_INVERT_BIT]),
		.sysref_aligned(sysref_aligned)
	);

	// Sample stream with optional SYSREF marker in the LSB
	csr_sample_marker #(
		.SAMPLE_W(SAMPLE_W)
	) i_csr_sample_marker (
		.ref_clk(ref_clk),
		.reset(reset),
		.sample_in(sample_in),
		.sysref_level(sysref_aligned),
		.marker_en(ctrl1_q[CSR_C1_MARKER_BIT]),
		.out_en(sample_marker_output_enable),
		.decim_factor(decim_factor),
		.sample_out(sample_out)
	);

	// Checks on the register side

	a_devclk_mode: // (R4)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c1 |=> device_clock_dc_coupled_mode == $past(reg_wdata[CSR_C1_DEVCLK_DC_BIT]))
	else $error("device clock mode not taken from bit 2");

	a_sysref_dc_mode: // (R5)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c1 |=> sysref_dc_coupled_mode == $past(reg_wdata[CSR_C1_SREF_DC_BIT]))
	else $error("sysref receiver mode not taken from bit 1");

	a_gain_hold: // (R6)
	assert property (@(posedge ref_clk) disable iff (reset)
		!wr_c2 |=> $stable(level_converter_gain_high))
	else $error("gain changed without a write");

	a_gain_write: // (R6)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c2 |=> level_converter_gain_high == $past(reg_wdata[CSR_C2_GAIN_BIT]))
	else $error("gain not taken from bit 4");

	a_delay_one_hot: // (R8)
	assert property (@(posedge ref_clk) disable iff (reset)
		is_one_hot2(sample_clock_delay_select))
	else $error("sample clock delay not one-hot");

	a_position_read: // (R9)
	assert property (@(posedge ref_clk) disable iff (reset)
		reg_rd && reg_hit(reg_addr, CSR_OFS_POS)
		|=> reg_rdata == {8'h00, $past(pos_q)} ##1 reg_rdata == '0 || $past(reg_rd))
	else $error("position word read wrong");

	a_position_track: // (R9)
	assert property (@(posedge ref_clk) disable iff (reset)
		!reset |=> pos_q == $past(sysref_edge_position_in))
	else $error("position word not captured");

	a_range_write: // (R11)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_range |=> input_a_range_trim == $past(reg_wdata[15:0]))
	else $error("range code not stored");

	a_reset_values: // (R13)
	assert property (@(posedge ref_clk)
		$fell(reset) |-> ctrl2_q == 8'h11 && ctrl1_q == 8'h00 && range_a_q == 16'ha000)
	else $error("control reset values wrong");

	a_delay_select: // (R14)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_sel |=> sysref_delay_select == $past(reg_wdata[3:0]))
	else $error("sysref delay select not stored");

	a_reserved_rb: // (R15)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c1 ##1 (reg_rd && reg_hit(reg_addr, CSR_OFS_CTRL1) && !reg_wr)
		|=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
	else $error("clock control 1 readback differs");

	// Registers only move on their own write strobe
	a_ctrl1_hold: // (R15)
	assert property (@(posedge ref_clk) disable iff (reset)
		!wr_c1 |=> $stable(ctrl1_q))
	else $error("clock control 1 changed without a write");

	a_ctrl2_hold: // (R15)
	assert property (@(posedge ref_clk) disable iff (reset)
		!wr_c2 |=> $stable(ctrl2_q))
	else $error("clock control 2 changed without a write");

	a_range_hold: // (R11)
	assert property (@(posedge ref_clk) disable iff (reset)
		!wr_range |=> $stable(input_a_range_trim))
	else $error("range code changed without a write");

	a_sel_hold: // (R14)
	assert property (@(posedge ref_clk) disable iff (reset)
		!wr_sel |=> $stable(sel_ctrl_q))
	else $error("delay select changed without a write");

	// Each used control bit lands on its own output, reserved bits stay in the register
	a_polarity_bit: // (R3)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c1 |=> sysref_polarity_invert == $past(reg_wdata[CSR_C1_INVERT_BIT]))
	else $error("polarity not taken from bit 0");

	a_marker_bit: // (R1)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c1 |=> sysref_marker_in_lsb_enable == $past(reg_wdata[CSR_C1_MARKER_BIT]))
	else $error("marker enable not taken from bit 3");

	a_ctrl1_reserved: // (R15)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c1 |=> ctrl1_q[7:4] == $past(reg_wdata[7:4]))
	else $error("clock control 1 reserved bits not stored");

	a_noise_bit: // (R7)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c2 |=> analog_supply_noise_suppress == $past(reg_wdata[CSR_C2_NOISE_BIT]))
	else $error("noise suppress not taken from bit 2");

	// A legal delay code is taken, any other leaves the taps alone
	a_delay_write: // (R8)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c2 && is_one_hot2(reg_wdata[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB])
		|=> sample_clock_delay_select == $past(reg_wdata[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB]))
	else $error("one-hot delay code not stored");

	a_delay_keep: // (R8)
	assert property (@(posedge ref_clk) disable iff (reset)
		wr_c2 && !is_one_hot2(reg_wdata[CSR_C2_DELAY_MSB:CSR_C2_DELAY_LSB])
		|=> $stable(sample_clock_delay_select))
	else $error("bad delay code changed the taps");

	// Read answer stands for one cycle and is zero otherwise
	a_rdata_idle: // (R9)
	assert property (@(posedge ref_clk) disable iff (reset)
		!reg_rd |=> reg_rdata == '0)
	else $error("read data not idle without a read");

	a_range_read: // (R11)
	assert property (@(posedge ref_clk) disable iff (reset)
		reg_rd && reg_hit(reg_addr, CSR_OFS_RANGE_A) |=> reg_rdata == {16'h0000, $past(range_a_q)})
	else $error("range code read wrong");

	a_ctrl2_read: // (R15)
	assert property (@(posedge ref_clk) disable iff (reset)
		reg_rd && reg_hit(reg_addr, CSR_OFS_CTRL2) |=> reg_rdata == {24'h000000, $past(ctrl2_q)})
	else $error("clock control 2 read wrong");

	// Low-range flag trails the stored code by one cycle
	a_range_low: // (R12)
	assert property (@(posedge ref_clk) disable iff (reset)
		!reset |=> input_a_range_low == ($past(range_a_q) < CSR_RANGE_MIN_REC))
	else $error("range low flag wrong");

endmodule
`default_nettype wire

// *** csr_pkg.sv ***
package csr_pkg;
	// Register bus geometry
	localparam int CSR_ADDR_W = 8;
	localparam int CSR_DATA_W = 32;

	// Register offsets
	localparam logic [7:0] CSR_OFS_SEL_CTRL = 8'h29;
	localparam logic [7:0] CSR_OFS_CTRL1 = 8'h2a;
	localparam logic [7:0] CSR_OFS_CTRL2 = 8'h2b;
	localparam logic [7:0] CSR_OFS_POS = 8'h2c;
	localparam logic [7:0] CSR_OFS_RANGE_A = 8'h30;

	// Reset values
	localparam logic [7:0] CSR_SEL_CTRL_RST = 8'h00;
	localparam logic [7:0] CSR_CTRL1_RST = 8'h00;
	localparam logic [7:0] CSR_CTRL2_RST = 8'h11;
	localparam logic [23:0] CSR_POS_RST = 24'h000000;
	localparam logic [15:0] CSR_RANGE_A_RST = 16'ha000;

	// Clock control 1 fields
	localparam int CSR_C1_INVERT_BIT = 0;
	localparam int CSR_C1_SREF_DC_BIT = 1;
	localparam int CSR_C1_DEVCLK_DC_BIT = 2;
	localparam int CSR_C1_MARKER_BIT = 3;

	// Clock control 2 fields
	localparam int CSR_C2_DELAY_LSB = 0;
	localparam int CSR_C2_DELAY_MSB = 1;
	localparam int CSR_C2_NOISE_BIT = 2;
	localparam int CSR_C2_GAIN_BIT = 4;

	// Delay selection field in the select control register
	localparam int CSR_SEL_LSB = 0;
	localparam int CSR_SEL_MSB = 3;

	// Field widths
	localparam int CSR_POS_W = 24;
	localparam int CSR_RANGE_W = 16;
	localparam int CSR_DECIM_W = 6;

	// Range code landmarks
	localparam logic [15:0] CSR_RANGE_MIN_REC = 16'h2000;

	// Decimation factor meaning bypass
	localparam logic [5:0] CSR_DECIM_BYPASS = 6'h01;

	// Pin synchroniser depth
	localparam int CSR_SYNC_STAGES = 2;
endpackage

// *** csr_sample_marker.sv ***
`timescale 1ns/1ns
`default_nettype none
module csr_sample_marker
	import csr_pkg::*;
#(
	parameter int SAMPLE_W = 12
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic sysref_level,
	input wire logic marker_en,
	input wire logic out_en,
	input wire logic [CSR_DECIM_W-1:0] decim_factor,
	output logic [SAMPLE_W-1:0] sample_out
);
	// Marker only legal when decimation is bypassed
	logic mark_now;
	logic [SAMPLE_W-1:0] sample_q;

	assign mark_now = marker_en && out_en && (decim_factor == CSR_DECIM_BYPASS); // (R1) (R2)

	// Registered sample stream, LSB replaced when marking
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sample_q <= '0;
		end else if (mark_now) begin
			sample_q <= {sample_in[SAMPLE_W-1:1], sysref_level}; // (R1)
		end else begin
			sample_q <= sample_in;
		end
	end

	assign sample_out = sample_q;

	a_marker_lsb: // (R1)
	assert property (@(posedge ref_clk) disable iff (reset)
		mark_now |=> sample_out[0] == $past(sysref_level)
			&& sample_out[SAMPLE_W-1:1] == $past(sample_in[SAMPLE_W-1:1]))
	else $error("marker not carried in sample lsb");

	a_decim_bypass: // (R2)
	assert property (@(posedge ref_clk) disable iff (reset)
		!reset && (decim_factor != CSR_DECIM_BYPASS) |=> sample_out == $past(sample_in))
	else $error("sample altered while decimating");
endmodule
`default_nettype wire

// *** csr_sysref_cond.sv ***
`timescale 1ns/1ns
`default_nettype none
module csr_sysref_cond
	import csr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sysref_pin,
	input wire logic invert,
	output logic sysref_aligned
);
	// Two-stage synchroniser; first stage feeds only the second
	logic sync1_q;
	logic sync2_q;
	logic aligned_q;

	// Pin arrives from outside the clock domain
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= sysref_pin;
			sync2_q <= sync1_q;
		end
	end

	// Polarity applied after the crossing
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			aligned_q <= 1'b0;
		end else begin
			aligned_q <= sync2_q ^ invert; // (R3)
		end
	end

	assign sysref_aligned = aligned_q;

	a_polarity_inv: // (R3)
	// Only once the pin has walked through both stages since reset
	assert property (@(posedge ref_clk) disable iff (reset)
		!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
		|-> sysref_aligned == ($past(sysref_pin, 3) ^ $past(invert)))
	else $error("sysref polarity path wrong");
endmodule
`default_nettype wire
